// ### include/acs_pkg.sv
// Purpose: Shared constants and types for the calibration sequencer.
// Assumes: Serial register access, clk_i as converter master clock.
// Notes: Output periods are counted in modulator cycles.
`default_nettype none
package acs_pkg;
   // Register select codes carried in the command byte
   localparam logic [2:0] REG_COMM = 3'h0;
   localparam logic [2:0] REG_SETUP = 3'h1;
   localparam logic [2:0] REG_CLOCK = 3'h2;
   localparam logic [2:0] REG_DATA = 3'h3;
   localparam logic [2:0] REG_ZERO_COEF = 3'h6;
   localparam logic [2:0] REG_FULL_COEF = 3'h7;
   // Command byte fields
   localparam int COMM_SEL_HI = 6;
   localparam int COMM_SEL_LO = 4;
   localparam int COMM_READ = 3;
   // Setup register fields
   localparam int SETUP_MODE_HI = 7;
   localparam int SETUP_MODE_LO = 6;
   localparam int SETUP_GAIN_HI = 5;
   localparam int SETUP_GAIN_LO = 4;
   localparam int SETUP_UNIPOLAR = 2;
   // Clock register fields
   localparam int CLOCK_RATE_HI = 1;
   localparam int CLOCK_RATE_LO = 0;
   // Reset values
   localparam logic [7:0] SETUP_RESET = 8'h01;
   localparam logic [7:0] CLOCK_RESET = 8'h00;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [15:0] ZERO_COEF_RESET = 16'h0000;
   localparam logic [15:0] FULL_COEF_RESET = 16'hffff;
   // Calibration mode codes
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_SELF = 2'h1,
      MODE_SYS_ZERO = 2'h2,
      MODE_SYS_FULL = 2'h3
   } acs_mode_t;
   // Conversion source select
   localparam logic [1:0] SRC_INPUT = 2'h0;
   localparam logic [1:0] SRC_SHORT = 2'h1;
   localparam logic [1:0] SRC_REF = 2'h2;
   // Step lengths in output periods
   localparam logic [3:0] ZERO_PERIODS = 4'h3;
   localparam logic [3:0] FULL_PERIODS = 4'h3;
   localparam logic [3:0] SELF_TAIL_PERIODS = 4'h3;
   localparam logic [3:0] SYS_TAIL_PERIODS = 4'h1;
   // Master clocks per modulator cycle
   localparam int MOD_DIV_DEFAULT = 128;
   // Modulator cycles per output period for each rate code
   localparam logic [9:0] RATE0_MODS = 10'h3c0;
   localparam logic [9:0] RATE1_MODS = 10'h300;
   localparam logic [9:0] RATE2_MODS = 10'h0c0;
   localparam logic [9:0] RATE3_MODS = 10'h060;
   // Serial frame bit counts
   localparam logic [5:0] CMD_LAST = 6'h07;
   localparam logic [5:0] WRITE_LAST = 6'h0f;
   localparam logic [5:0] READ_LOAD = 6'h0b;
   localparam logic [5:0] CNT_MAX = 6'h3f;
endpackage
`default_nettype wire

// ### hdl/acs_serial_link.sv
// Purpose: Serial port of the sequencer, clocked by the link clock.
// Assumes: Bits taken on rising sclk_i edges, MSB first, frame while cs_n_i low.
// Notes: Words cross to the core by toggle handshakes only.
`default_nettype none
module acs_serial_link
(
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic resetn_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic [2:0] wr_sel_o,
   output logic [7:0] wr_data_o,
   output logic wr_tgl_o,
   output logic [2:0] rd_sel_o,
   output logic rd_tgl_o,
   input wire logic [15:0] rd_word_i,
   input wire logic rd_ack_tgl_i
);
   import acs_pkg::*;

   logic frame_rst;
   logic [5:0] bit_cnt;
   logic [6:0] in_sr;
   logic [7:0] in_byte;
   logic cmd_read;
   logic [2:0] cmd_sel;
   logic ack_s1;
   logic ack_s2;
   logic [15:0] out_sr;
   logic [15:0] load_word;

   // Frame ends as soon as select rises
   assign frame_rst = cs_n_i | ~resetn_i;
   assign in_byte = {in_sr, din_i};
   // Word is only trusted once the acknowledge has crossed
   assign load_word = (ack_s2 == rd_tgl_o) ? rd_word_i : 16'h0000;

   // Bit counter and input shifter
   always_ff @(posedge sclk_i or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         bit_cnt <= 6'h00;
         in_sr <= 7'h00;
      end
      else
      begin
         if (bit_cnt != CNT_MAX)
            bit_cnt <= bit_cnt + 6'h01;
         in_sr <= in_byte[6:0];
      end
   end

   // Command decode and read request
   always_ff @(posedge sclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cmd_read <= 1'b0;
         cmd_sel <= REG_COMM;
         rd_sel_o <= REG_COMM;
         rd_tgl_o <= 1'b0;
      end
      else if (bit_cnt == CMD_LAST)
      begin
         cmd_read <= in_byte[COMM_READ];
         cmd_sel <= in_byte[COMM_SEL_HI:COMM_SEL_LO];
         if (in_byte[COMM_READ])
         begin
            rd_sel_o <= in_byte[COMM_SEL_HI:COMM_SEL_LO];
            rd_tgl_o <= ~rd_tgl_o;
         end
      end
   end

   // Write word handed to the core
   always_ff @(posedge sclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_sel_o <= REG_COMM;
         wr_data_o <= 8'h00;
         wr_tgl_o <= 1'b0;
      end
      else if (bit_cnt == WRITE_LAST && !cmd_read)
      begin
         wr_sel_o <= cmd_sel;
         wr_data_o <= in_byte;
         wr_tgl_o <= ~wr_tgl_o;
      end
   end

   // Acknowledge synchroniser
   always_ff @(posedge sclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= rd_ack_tgl_i;
         ack_s2 <= ack_s1;
      end
   end

   // Read data shifter and output enable
   always_ff @(posedge sclk_i or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         out_sr <= 16'h0000;
         dout_o <= 1'b0;
         dout_oe_o <= 1'b0;
      end
      else if (bit_cnt == READ_LOAD && cmd_read)
      begin
         out_sr <= load_word;
         dout_o <= load_word[15];
         dout_oe_o <= 1'b1;
      end
      else if (dout_oe_o)
      begin
         out_sr <= {out_sr[14:0], 1'b0};
         dout_o <= out_sr[14];
      end
   end
endmodule
`default_nettype wire

// ### hdl/acs_cal_seq.sv
// Purpose: Calibration sequencer and register core of a sigma-delta converter.
// Assumes: sample_i holds the filter result for the source chosen by src_sel_o.
// Notes: Serial link runs on sclk_i; all crossings use toggles.
`default_nettype none
// Notes on behaviour
// - A nonzero mode write to setup starts calibration at any time.
// - Mode 01 self-calibrates zero point on shorted inputs at selected gain.
// - Self-calibration full point uses internal reference over gain, same gain.
// - Self-calibration lasts six periods, three each, then mode clears.
// - Self-calibration raises ready, lowers it after nine periods.
// - Ready may take one modulator cycle to rise after the command.
// - Bipolar self-calibration maps shorted-input point to midscale.
// - Zero result goes to zero coefficient, full result to full coefficient.
// - Result derivation keeps 33 bits of internal precision.
// - Mode 10 calibrates system zero on the input for three periods.
// - System steps raise ready and lower it after four periods.
// - Mode 11 calibrates system full scale on the input for three periods.
// - Unipolar spans endpoints; bipolar spans midscale to positive full scale.
// - Updating one coefficient leaves the other unchanged.
// - Reset loads defaults, nominal values in both coefficient registers.
// - Output period follows the rate select bits of the clock register.
module acs_cal_seq
#(
   parameter int MOD_DIV = acs_pkg::MOD_DIV_DEFAULT
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic [15:0] sample_i,
   output logic result_ready_n_o,
   output logic [1:0] src_sel_o,
   output logic [1:0] gain_sel_o,
   output logic bipolar_o
);
   import acs_pkg::*;

   typedef enum logic [4:0] {
      ST_RUN = 5'b00001,
      ST_ARM = 5'b00010,
      ST_ZERO = 5'b00100,
      ST_FULL = 5'b01000,
      ST_TAIL = 5'b10000
   } acs_state_t;

   acs_state_t state;
   acs_mode_t cal_code;
   acs_mode_t mode;
   logic [2:0] wr_sel;
   logic [7:0] wr_data;
   logic wr_tgl;
   logic [2:0] rd_sel;
   logic rd_tgl;
   logic [15:0] rd_word;
   logic rd_ack_tgl;
   logic wr_s1, wr_s2, wr_s3;
   logic rd_s1, rd_s2, rd_s3;
   logic wr_evt, rd_evt, setup_wr, cal_req;
   logic [5:0] setup_low;
   logic [7:0] clock_reg;
   logic [15:0] data_reg, zero_coef, full_coef;
   logic [15:0] mod_cnt;
   logic [9:0] per_cnt, per_len;
   logic [3:0] step_cnt;
   logic mod_tick, period_end, last_period, cal_done, new_word, start;
   logic self_cal;

   // Output period length in modulator cycles
   function automatic logic [9:0] rate_mods(input logic [1:0] rate);
      logic [9:0] len;
      unique case (rate)
         2'h0: len = RATE0_MODS;
         2'h1: len = RATE1_MODS;
         2'h2: len = RATE2_MODS;
         2'h3: len = RATE3_MODS;
      endcase
      return len;
   endfunction

   // Calibrated result from raw sample and both coefficients
   function automatic logic [15:0] calibrate(input logic [15:0] raw, input logic [15:0] zero,
                                             input logic [15:0] full, input logic bip);
      logic signed [32:0] num;
      logic signed [32:0] span;
      logic signed [32:0] quo;
      logic [15:0] res;
      num = $signed({17'h00000, raw}) - $signed({17'h00000, zero});
      span = $signed({17'h00000, full}) - $signed({17'h00000, zero});
      num = bip ? (num <<< 15) : (num <<< 16);
      if (span <= 33'sh000000000)
         span = 33'sh000000001;
      quo = num / span;
      if (bip)
         quo = quo + 33'sh000008000;
      if (quo < 33'sh000000000)
         res = 16'h0000;
      else if (quo > 33'sh00000ffff)
         res = 16'hffff;
      else
         res = quo[15:0];
      return res;
   endfunction

   acs_serial_link u_link (
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .resetn_i(resetn_i),
      .din_i(din_i),
      .dout_o(dout_o),
      .dout_oe_o(dout_oe_o),
      .wr_sel_o(wr_sel),
      .wr_data_o(wr_data),
      .wr_tgl_o(wr_tgl),
      .rd_sel_o(rd_sel),
      .rd_tgl_o(rd_tgl),
      .rd_word_i(rd_word),
      .rd_ack_tgl_i(rd_ack_tgl)
   );

   // Toggle synchronisers from the link domain
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         {wr_s1, wr_s2, wr_s3} <= 3'h0;
         {rd_s1, rd_s2, rd_s3} <= 3'h0;
      end
      else
      begin
         {wr_s1, wr_s2, wr_s3} <= {wr_tgl, wr_s1, wr_s2};
         {rd_s1, rd_s2, rd_s3} <= {rd_tgl, rd_s1, rd_s2};
      end
   end

   // Event decode
   assign wr_evt = wr_s2 ^ wr_s3;
   assign rd_evt = rd_s2 ^ rd_s3;
   assign setup_wr = wr_evt && (wr_sel == REG_SETUP);
   assign cal_req = setup_wr && (wr_data[SETUP_MODE_HI:SETUP_MODE_LO] != MODE_NORMAL);
   assign self_cal = (cal_code == MODE_SELF);
   assign per_len = rate_mods(clock_reg[CLOCK_RATE_HI:CLOCK_RATE_LO]);
   assign mod_tick = (mod_cnt == 16'(MOD_DIV - 1));
   assign start = (state == ST_ARM) && mod_tick;
   assign period_end = mod_tick && (per_cnt == per_len - 10'h001) && (state != ST_ARM);
   assign last_period = period_end && (step_cnt == 4'h1) && !cal_req;
   assign cal_done = last_period && (state == ST_FULL || (state == ST_ZERO && !self_cal));
   assign new_word = period_end && !cal_req
                     && (state == ST_RUN || (state == ST_TAIL && step_cnt == 4'h1));

   // Modulator cycle and output period timers
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mod_cnt <= 16'h0000;
         per_cnt <= 10'h000;
      end
      else
      begin
         mod_cnt <= mod_tick ? 16'h0000 : mod_cnt + 16'h0001;
         if (start)
            per_cnt <= 10'h000;
         else if (mod_tick)
            per_cnt <= (per_cnt >= per_len - 10'h001) ? 10'h000 : per_cnt + 10'h001;
      end
   end

   // Calibration sequence
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state <= ST_RUN;
         step_cnt <= 4'h0;
         cal_code <= MODE_NORMAL;
      end
      else if (cal_req)
      begin
         state <= ST_ARM;
         cal_code <= acs_mode_t'(wr_data[SETUP_MODE_HI:SETUP_MODE_LO]);
      end
      else
      begin
         unique case (state)
            ST_RUN: state <= ST_RUN;
            ST_ARM:
               // Start waits for a modulator cycle edge
               if (start)
               begin
                  state <= (cal_code == MODE_SYS_FULL) ? ST_FULL : ST_ZERO;
                  step_cnt <= (cal_code == MODE_SYS_FULL) ? FULL_PERIODS : ZERO_PERIODS;
               end
            ST_ZERO:
               if (last_period)
               begin
                  state <= self_cal ? ST_FULL : ST_TAIL;
                  step_cnt <= self_cal ? FULL_PERIODS : SYS_TAIL_PERIODS;
               end
               else if (period_end)
                  step_cnt <= step_cnt - 4'h1;
            ST_FULL:
               if (last_period)
               begin
                  state <= ST_TAIL;
                  step_cnt <= self_cal ? SELF_TAIL_PERIODS : SYS_TAIL_PERIODS;
               end
               else if (period_end)
                  step_cnt <= step_cnt - 4'h1;
            ST_TAIL:
               if (last_period)
                  state <= ST_RUN;
               else if (period_end)
                  step_cnt <= step_cnt - 4'h1;
            default: state <= ST_RUN;
         endcase
      end
   end

   // Mode field, new command wins over completion
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         mode <= acs_mode_t'(SETUP_RESET[SETUP_MODE_HI:SETUP_MODE_LO]);
      else if (cal_req)
         mode <= acs_mode_t'(wr_data[SETUP_MODE_HI:SETUP_MODE_LO]);
      else if (cal_done)
         mode <= MODE_NORMAL;
   end

   // Setup low fields and clock register
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         setup_low <= SETUP_RESET[5:0];
         clock_reg <= CLOCK_RESET;
      end
      else if (setup_wr)
         setup_low <= wr_data[5:0];
      else if (wr_evt && wr_sel == REG_CLOCK)
         clock_reg <= wr_data;
   end

   // Coefficient capture at end of each calibration step
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         zero_coef <= ZERO_COEF_RESET;
         full_coef <= FULL_COEF_RESET;
      end
      else if (last_period && state == ST_ZERO)
         zero_coef <= sample_i;
      else if (last_period && state == ST_FULL)
         full_coef <= sample_i;
   end

   // Data register from calibrated conversions
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         data_reg <= DATA_RESET;
      else if (new_word)
         data_reg <= calibrate(sample_i, zero_coef, full_coef, ~setup_low[SETUP_UNIPOLAR]);
   end

   // Result-ready line
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         result_ready_n_o <= 1'b1;
      else if (start)
         result_ready_n_o <= 1'b1;
      else if (new_word)
         result_ready_n_o <= 1'b0;
      else if (rd_evt && rd_sel == REG_DATA)
         result_ready_n_o <= 1'b1;
   end

   // Read reply to the link
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rd_word <= 16'h0000;
         rd_ack_tgl <= 1'b0;
      end
      else if (rd_evt)
      begin
         rd_ack_tgl <= rd_s2;
         unique case (rd_sel)
            REG_SETUP: rd_word <= {mode, setup_low, 8'h00};
            REG_CLOCK: rd_word <= {clock_reg, 8'h00};
            REG_DATA: rd_word <= data_reg;
            REG_ZERO_COEF: rd_word <= zero_coef;
            REG_FULL_COEF: rd_word <= full_coef;
            default: rd_word <= 16'h0000;
         endcase
      end
   end

   // Converter front-end controls
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         src_sel_o <= SRC_INPUT;
         gain_sel_o <= SETUP_RESET[SETUP_GAIN_HI:SETUP_GAIN_LO];
         bipolar_o <= ~SETUP_RESET[SETUP_UNIPOLAR];
      end
      else
      begin
         if (state == ST_ZERO && self_cal)
            src_sel_o <= SRC_SHORT;
         else if (state == ST_FULL && self_cal)
            src_sel_o <= SRC_REF;
         else
            src_sel_o <= SRC_INPUT;
         gain_sel_o <= setup_low[SETUP_GAIN_HI:SETUP_GAIN_LO];
         bipolar_o <= ~setup_low[SETUP_UNIPOLAR];
      end
   end
endmodule
`default_nettype wire

// ### bench/acs_cal_seq_props.sv
// Purpose: Port checker for the calibration sequencer.
// Assumes: Rate code is not visible here, so step lengths are cross-checked.
// Notes: Bound below to every sequencer instance.
`default_nettype none
module acs_cal_seq_props
#(
   parameter int MOD_DIV = 4
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic dout_oe_o,
   input wire logic result_ready_n_o,
   input wire logic [1:0] src_sel_o,
   input wire logic [1:0] gain_sel_o,
   input wire logic bipolar_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Z0 = 2880 * MOD_DIV;
   localparam int Z1 = 2304 * MOD_DIV;
   localparam int Z2 = 576 * MOD_DIV;
   localparam int Z3 = 288 * MOD_DIV;
   logic [1:0] src_q;
   logic [15:0] run_len;
   logic [15:0] zero_len;
   logic [15:0] tail;
   logic tail_on;
   logic [4:0] edge_cnt;
   wire logic leave = src_sel_o != src_q;
   // Length of the current source run
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         src_q <= 2'h0;
         run_len <= 16'h0;
      end
      else
      begin
         src_q <= src_sel_o;
         run_len <= leave ? 16'h1 : run_len + 16'h1;
      end
   end
   // Zero step length, the yardstick for later steps
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
         zero_len <= 16'h0;
      else if (leave && src_q == 2'h1)
         zero_len <= run_len;
   // Tail from the end of the full step to ready low
   // Source trails its state one cycle longer than ready does, so start at two
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         tail_on <= 1'b0;
         tail <= 16'h0;
      end
      else if (leave && src_q == 2'h2)
      begin
         tail_on <= 1'b1;
         tail <= 16'h2;
      end
      else
      begin
         tail_on <= tail_on && result_ready_n_o;
         tail <= tail + 16'h1;
      end
   // Link edges since the frame opened
   always_ff @(posedge sclk_i or posedge cs_n_i)
      if (cs_n_i)
         edge_cnt <= 5'h0;
      else if (edge_cnt != 5'h1f)
         edge_cnt <= edge_cnt + 5'h1;
   AST_RESET_OUT: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> result_ready_n_o && src_sel_o == 2'h0 && gain_sel_o == 2'h0
      && bipolar_o && !dout_oe_o) else $error("outputs not at reset values");
   AST_SRC_LEGAL: assert property (@(posedge clk_i) disable iff (!resetn_i)
      src_sel_o != 2'h3) else $error("illegal source select");
   AST_READY_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
      src_sel_o != 2'h0 |-> result_ready_n_o) else $error("ready low during calibration");
   AST_ZERO_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
      leave && src_q == 2'h1 |-> run_len inside {Z0, Z1, Z2, Z3})
      else $error("zero step not three periods");
   AST_ZERO_TO_FULL: assert property (@(posedge clk_i) disable iff (!resetn_i)
      leave && src_q == 2'h1 |-> src_sel_o == 2'h2) else $error("full step not after zero");
   AST_FULL_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
      leave && src_q == 2'h2 |-> run_len == zero_len && src_sel_o == 2'h0)
      else $error("full step length differs from zero step");
   AST_TAIL_LEN: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(result_ready_n_o) && tail_on |-> tail == zero_len)
      else $error("ready not low three periods after full step");
   AST_OE_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cs_n_i [*2] |-> !dout_oe_o) else $error("data out driven outside frame");
   AST_OE_TURN: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      dout_oe_o |-> edge_cnt >= 5'd12) else $error("data out driven before turnaround");
   cover property (@(posedge clk_i) leave && src_q == 2'h2);
   cover property (@(posedge clk_i) $fell(result_ready_n_o));
   cover property (@(posedge sclk_i) $rose(dout_oe_o));
endmodule
bind acs_cal_seq acs_cal_seq_props #(.MOD_DIV(MOD_DIV)) u_props (.clk_i(clk_i),
   .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_oe_o(dout_oe_o),
   .result_ready_n_o(result_ready_n_o), .src_sel_o(src_sel_o), .gain_sel_o(gain_sel_o),
   .bipolar_o(bipolar_o));
`default_nettype wire

// ### bench/acs_host_model.sv
// Purpose: Host controller model on the serial port.
// Assumes: Link clock of 48 ns, idle high and still between frames.
// Notes: A released data line shows the inverse of its last bit.
`default_nettype none
module acs_host_model
(
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i,
   output logic [15:0] rd_word_o,
   output logic rd_evt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels
   initial
   begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b0;
      rd_word_o = 16'h0;
      rd_evt_o = 1'b0;
   end
   // One frame: command, then data byte or turnaround and read bits
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, input int nrd);
      int n;
      logic [15:0] w;
      n = cmd[3] ? 12 + nrd : 16;
      w = 16'h0;
      cs_n_o = 1'b0;
      #24;
      for (int k = 1; k <= n; k++)
      begin
         sclk_o = 1'b0;
         if (k <= 8)
            din_o = cmd[8-k];
         else if (k <= 16 && !cmd[3])
            din_o = wdat[16-k];
         else
            din_o = ~din_o; // Meaningless turnaround bits
         #24;
         if (cmd[3] && k > 12)
            w = {w[14:0], dout_i};
         sclk_o = 1'b1;
         #24;
      end
      cs_n_o = 1'b1;
      din_o = ~din_o; // Line released
      #48;
      if (cmd[3])
      begin
         rd_word_o = w << (16 - nrd);
         rd_evt_o = ~rd_evt_o;
      end
   endtask
endmodule
`default_nettype wire

// ### bench/acs_cal_seq_bench.sv
// Purpose: Self-checking bench for the calibration sequencer.
// Assumes: MOD_DIV of 4 keeps output periods short.
// Notes: Read words are checked in order by a watcher process.
`default_nettype none
module acs_cal_seq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import acs_pkg::*;
   localparam int MD = 4;
   localparam logic [9:0] RM [4] = '{RATE0_MODS, RATE1_MODS, RATE2_MODS, RATE3_MODS};
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sclk, cs_n, din, dout, dout_oe, ready_n, bip, evt;
   logic [1:0] src, gain;
   logic [15:0] sample_i = 16'h0;
   logic [15:0] rd_word, v;
   logic [15:0] samp [4] = '{default: 16'h0};
   logic [15:0] exp_q [$];
   logic [31:0] seed = 32'd7477;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   acs_cal_seq #(.MOD_DIV(MD)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .sample_i(sample_i),
      .result_ready_n_o(ready_n), .src_sel_o(src), .gain_sel_o(gain), .bipolar_o(bip));
   acs_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
      .rd_word_o(rd_word), .rd_evt_o(evt));
   always #5 clk_i = ~clk_i;
   // Filter result follows the selected source
   always @(posedge clk_i)
      sample_i <= #1 samp[src];
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [15:0] uni(input logic [15:0] r, lo, hi);
      logic [32:0] q;
      q = ({17'h0, r - lo} << 16) / {17'h0, hi - lo};
      return (q > 33'hffff) ? 16'hffff : q[15:0];
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("Counts: %0d checks, %0d failures", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      u_host.xfer({1'b0, sel, 4'h0}, d, 0);
      repeat (8) @(posedge clk_i);
      #1;
   endtask
   task automatic rd(input logic [2:0] sel, input int bits, input logic [15:0] e);
      exp_q.push_back(e);
      u_host.xfer({1'b0, sel, 4'h8}, 8'h0, bits);
   endtask
   // One calibration step, timed from the command to ready low
   task automatic cal(input logic [7:0] s, input int per, input int len);
      time t0;
      int lim;
      lim = per * len + 400;
      wr(REG_SETUP, s);
      t0 = $time - 81;
      check("ready up", {15'h0, ready_n}, 16'h1);
      check("gain", {14'h0, gain}, {14'h0, s[5:4]});
      check("polarity", {15'h0, bip}, {15'h0, !s[2]});
      rd(REG_SETUP, 8, {s, 8'h0});
      while (ready_n === 1'b1 && lim > 0)
      begin
         @(posedge clk_i);
         #1;
         lim--;
      end
      n = int'(($time - t0) / 10);
      check("ready delay", 16'(n > per * len - 8 && n < per * len + 6), 16'h1);
      rd(REG_SETUP, 8, {2'h0, s[5:0], 8'h0});
   endtask
   // Each finished read is matched against the oldest note
   always @(evt)
      if (exp_q.size() > 0)
         check("read word", rd_word, exp_q.pop_front());
   // Cycle ceiling against a hang
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         failures++;
         $display("ERROR timeout expected finish seen hang");
         wrap_up();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      rd(REG_SETUP, 8, {SETUP_RESET, 8'h0});
      rd(REG_CLOCK, 8, {CLOCK_RESET, 8'h0});
      rd(REG_ZERO_COEF, 16, ZERO_COEF_RESET);
      rd(REG_FULL_COEF, 16, FULL_COEF_RESET);
      rd(3'h4, 16, 16'h0);
      $display("Test reset values done");
      v = rnd();
      samp[0] = {4'h8, v[11:0]};
      samp[1] = {4'h0, v[11:0]};
      samp[2] = {4'hf, v[15:4]};
      wr(REG_CLOCK, 8'h03);
      cal(8'h64, 9, RM[3] * MD);
      rd(REG_ZERO_COEF, 16, samp[1]);
      rd(REG_FULL_COEF, 16, samp[2]);
      rd(REG_DATA, 16, uni(samp[0], samp[1], samp[2]));
      $display("Test self calibration done");
      for (int r = 0; r < 4; r++)
      begin
         v = rnd();
         samp[0] = {4'h1, v[11:0]};
         wr(REG_CLOCK, 8'(r));
         cal(8'ha4, 4, RM[r] * MD);
         rd(REG_ZERO_COEF, 16, samp[0]);
         rd(REG_FULL_COEF, 16, samp[2]);
         rd(REG_DATA, 16, 16'h0000);
         samp[2] = {4'he, v[15:4]};
         samp[0] = samp[2];
         cal(8'he4, 4, RM[r] * MD);
         rd(REG_FULL_COEF, 16, samp[2]);
         rd(REG_ZERO_COEF, 16, {4'h1, v[11:0]});
         rd(REG_DATA, 16, 16'hffff);
      end
      $display("Test system calibration done");
      samp[0] = {4'h2, v[11:0]};
      cal(8'ha0, 4, RM[3] * MD);
      rd(REG_DATA, 16, 16'h8000);
      $display("Test bipolar calibration done");
      wrap_up();
   end
endmodule
`default_nettype wire
